/* File: rtl/cxp_pkg.sv */
// constants and types shared by the compressed expander
package cxp_pkg;
  // opcode quadrants held in the two lowest bits
  localparam logic [1:0] QUAD0 = 2'h0;
  localparam logic [1:0] QUAD1 = 2'h1;
  localparam logic [1:0] QUAD2 = 2'h2;
  localparam logic [1:0] QUAD_FULL = 2'h3;
  // compact function_code_3bit values
  localparam logic [2:0] F3_WIDE = 3'h0;
  localparam logic [2:0] F3_QUAD_DBLF = 3'h1;
  localparam logic [2:0] F3_WORD = 3'h2;
  localparam logic [2:0] F3_DBL_SGLF = 3'h3;
  localparam logic [2:0] F3_MISC = 3'h4;
  localparam logic [2:0] F3_ST_QUAD_DBLF = 3'h5;
  localparam logic [2:0] F3_ST_WORD = 3'h6;
  localparam logic [2:0] F3_ST_DBL_SGLF = 3'h7;
  // full-width major opcodes
  localparam logic [6:0] OPC_LOAD = 7'h03;
  localparam logic [6:0] OPC_LOAD_FP = 7'h07;
  localparam logic [6:0] OPC_MISC_MEM = 7'h0F;
  localparam logic [6:0] OPC_OP_IMM = 7'h13;
  localparam logic [6:0] OPC_STORE = 7'h23;
  localparam logic [6:0] OPC_STORE_FP = 7'h27;
  // full-width function codes
  localparam logic [2:0] BF3_ADD = 3'h0;
  localparam logic [2:0] BF3_WORD = 3'h2;
  localparam logic [2:0] BF3_DOUBLE = 3'h3;
  localparam logic [2:0] BF3_QUAD_LD = 3'h2;
  localparam logic [2:0] BF3_QUAD_ST = 3'h4;
  // registers and field positions
  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [4:0] REG_SP = 5'h02;
  localparam logic [1:0] COMPACT_HI = 2'h1;
  localparam int CMP_FIELD_LSB = 2;
  localparam int CMP_FIELD_STEP = 5;
  localparam int SIGN_BIT = 12;
  localparam logic [31:0] INST_RESET = 32'h0000_0000;
  // base widths
  localparam int XLEN_NARROW = 32;
  localparam int XLEN_WIDE = 64;
  localparam int XLEN_QUAD = 128;

  typedef enum logic [3:0] {
    LAY_REG = 4'h0,
    LAY_IMM = 4'h1,
    LAY_SSTORE = 4'h2,
    LAY_WIDE = 4'h3,
    LAY_LOAD = 4'h4,
    LAY_STORE = 4'h5,
    LAY_ARITH = 4'h6,
    LAY_BRANCH = 4'h7,
    LAY_JUMP = 4'h8,
    LAY_NONE = 4'h9
  } cxp_layout_t;

  typedef enum logic [1:0] {
    SZ_WORD = 2'h0,
    SZ_DOUBLE = 2'h1,
    SZ_QUAD = 2'h2
  } cxp_size_t;
endpackage : cxp_pkg

/* File: rtl/cxp_fields_if.sv */
// decoded fields passed from the field extractor to the expander
`timescale 1ns/10ps
`default_nettype none
interface cxp_fields_if;
  logic [15:0] inst;
  cxp_pkg::cxp_layout_t layout;
  logic [1:0][4:0] cmpReg;
  logic [31:0] signImm;
  logic [2:0][11:0] ldOff;
  logic [2:0][11:0] stOff;
  logic [11:0] wideImm;
  modport producer(input inst, output layout, cmpReg, signImm, ldOff, stOff, wideImm);
  modport consumer(output inst, input layout, cmpReg, signImm, ldOff, stOff, wideImm);
endinterface : cxp_fields_if
`default_nettype wire

/* File: rtl/cxp_field_extract.sv */
// layout recognition, compact registers and offset unscrambling
`timescale 1ns/10ps
`default_nettype none
module cxp_field_extract #(
  parameter int XLEN = 32
) (
  cxp_fields_if.producer fld
);
  logic [15:0] i;
  assign i = fld.inst;

  // compact fields name x8..x15 / f8..f15
  for (genvar g = 0; g < 2; g++) begin : g_cmp
    assign fld.cmpReg[g] = {cxp_pkg::COMPACT_HI, i[cxp_pkg::CMP_FIELD_LSB + g * cxp_pkg::CMP_FIELD_STEP +: 3]};
  end

  assign fld.signImm = {{26{i[cxp_pkg::SIGN_BIT]}}, i[cxp_pkg::SIGN_BIT], i[6:2]};

  assign fld.ldOff[cxp_pkg::SZ_WORD] = {4'h0, i[3:2], i[12], i[6:4], 2'h0};
  assign fld.ldOff[cxp_pkg::SZ_DOUBLE] = {3'h0, i[4:2], i[12], i[6:5], 3'h0};
  assign fld.ldOff[cxp_pkg::SZ_QUAD] = {2'h0, i[5:2], i[12], i[6], 4'h0};
  assign fld.stOff[cxp_pkg::SZ_WORD] = {4'h0, i[8:7], i[12:9], 2'h0};
  assign fld.stOff[cxp_pkg::SZ_DOUBLE] = {3'h0, i[9:7], i[12:10], 3'h0};
  assign fld.stOff[cxp_pkg::SZ_QUAD] = {2'h0, i[10:7], i[12:11], 4'h0};
  assign fld.wideImm = {2'h0, i[10:7], i[12:11], i[5], i[6], 2'h0};

  always_comb begin
    fld.layout = cxp_pkg::LAY_NONE;
    case (i[1:0])
      cxp_pkg::QUAD0: begin
        if (i[15:13] == cxp_pkg::F3_WIDE) begin
          fld.layout = cxp_pkg::LAY_WIDE;
        end else if (i[15:13] == cxp_pkg::F3_MISC) begin
          fld.layout = cxp_pkg::LAY_NONE;
        end else if (i[15]) begin
          fld.layout = cxp_pkg::LAY_STORE;
        end else begin
          fld.layout = cxp_pkg::LAY_LOAD;
        end
      end
      cxp_pkg::QUAD1: begin
        case (i[15:13])
          3'h1: fld.layout = (XLEN == cxp_pkg::XLEN_NARROW) ? cxp_pkg::LAY_JUMP : cxp_pkg::LAY_IMM;
          3'h4: fld.layout = (i[11:10] == 2'h3) ? cxp_pkg::LAY_ARITH : cxp_pkg::LAY_BRANCH;
          3'h5: fld.layout = cxp_pkg::LAY_JUMP;
          3'h6, 3'h7: fld.layout = cxp_pkg::LAY_BRANCH;
          default: fld.layout = cxp_pkg::LAY_IMM;
        endcase
      end
      cxp_pkg::QUAD2: begin
        if (i[15:13] == cxp_pkg::F3_MISC) begin
          fld.layout = cxp_pkg::LAY_REG;
        end else if (i[15]) begin
          fld.layout = cxp_pkg::LAY_SSTORE;
        end else begin
          fld.layout = cxp_pkg::LAY_IMM;
        end
      end
      default: fld.layout = cxp_pkg::LAY_NONE;
    endcase
  end
endmodule : cxp_field_extract
`default_nettype wire

/* File: rtl/cxp_expander.sv */
// stack-pointer load/store and wide-immediate expander, one-cycle registered
`timescale 1ns/10ps
`default_nettype none
module cxp_expander #(
  parameter int XLEN = 32,
  parameter bit HAS_F = 1'b1,
  parameter bit HAS_D = 1'b1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic inValid,
  input wire logic [15:0] inst,
  output logic outValid,
  output logic outHandled,
  output logic outIllegal,
  output logic [31:0] outInst,
  output logic [31:0] outImm,
  output cxp_pkg::cxp_layout_t outLayout
);
  cxp_fields_if fld();
  assign fld.inst = inst;

  cxp_field_extract #(
    .XLEN(XLEN)
  ) u_fields (
    .fld(fld)
  );

  logic outValid_reg;
  logic outHandled_reg;
  logic outIllegal_reg;
  logic [31:0] outInst_reg;
  logic [31:0] outImm_reg;
  cxp_pkg::cxp_layout_t outLayout_reg;
  logic handled_next;
  logic illegal_next;
  logic [31:0] inst_next;

  function automatic logic [31:0] itype(input logic [11:0] imm, input logic [4:0] base, input logic [2:0] f3,
                                        input logic [4:0] rd, input logic [6:0] opc);
    itype = {imm, base, f3, rd, opc};
  endfunction : itype

  function automatic logic [31:0] stype(input logic [11:0] imm, input logic [4:0] src, input logic [4:0] base,
                                        input logic [2:0] f3, input logic [6:0] opc);
    stype = {imm[11:5], src, base, f3, imm[4:0], opc};
  endfunction : stype

  logic [4:0] fullDest;
  logic [4:0] fullSrc2;
  logic destZero;
  logic isWide;
  logic isQuad;
  assign fullDest = inst[11:7];
  assign fullSrc2 = inst[6:2];
  assign destZero = (fullDest == cxp_pkg::REG_ZERO);
  assign isWide = (XLEN >= cxp_pkg::XLEN_WIDE);
  assign isQuad = (XLEN == cxp_pkg::XLEN_QUAD);

  always_comb begin
    handled_next = 1'b0;
    illegal_next = 1'b0;
    inst_next = cxp_pkg::INST_RESET;
    if (inst[1:0] == cxp_pkg::QUAD2) begin
      case (inst[15:13])
        cxp_pkg::F3_WORD: begin
          handled_next = 1'b1;
          if (destZero) begin
            illegal_next = 1'b1;
          end else begin
            inst_next = itype(fld.ldOff[cxp_pkg::SZ_WORD], cxp_pkg::REG_SP, cxp_pkg::BF3_WORD, fullDest,
                              cxp_pkg::OPC_LOAD);
          end
        end
        cxp_pkg::F3_DBL_SGLF: begin
          handled_next = 1'b1;
          if (isWide) begin
            illegal_next = destZero;
            inst_next = destZero ? cxp_pkg::INST_RESET : itype(fld.ldOff[cxp_pkg::SZ_DOUBLE], cxp_pkg::REG_SP,
                                                               cxp_pkg::BF3_DOUBLE, fullDest, cxp_pkg::OPC_LOAD);
          end else if (HAS_F) begin
            inst_next = itype(fld.ldOff[cxp_pkg::SZ_WORD], cxp_pkg::REG_SP, cxp_pkg::BF3_WORD, fullDest,
                              cxp_pkg::OPC_LOAD_FP);
          end else begin
            illegal_next = 1'b1;
          end
        end
        cxp_pkg::F3_QUAD_DBLF: begin
          handled_next = 1'b1;
          if (isQuad) begin
            illegal_next = destZero;
            inst_next = destZero ? cxp_pkg::INST_RESET : itype(fld.ldOff[cxp_pkg::SZ_QUAD], cxp_pkg::REG_SP,
                                                               cxp_pkg::BF3_QUAD_LD, fullDest, cxp_pkg::OPC_MISC_MEM);
          end else if (HAS_D) begin
            inst_next = itype(fld.ldOff[cxp_pkg::SZ_DOUBLE], cxp_pkg::REG_SP, cxp_pkg::BF3_DOUBLE, fullDest,
                              cxp_pkg::OPC_LOAD_FP);
          end else begin
            illegal_next = 1'b1;
          end
        end
        cxp_pkg::F3_ST_WORD: begin
          handled_next = 1'b1;
          inst_next = stype(fld.stOff[cxp_pkg::SZ_WORD], fullSrc2, cxp_pkg::REG_SP, cxp_pkg::BF3_WORD,
                            cxp_pkg::OPC_STORE);
        end
        cxp_pkg::F3_ST_DBL_SGLF: begin
          handled_next = 1'b1;
          if (isWide) begin
            inst_next = stype(fld.stOff[cxp_pkg::SZ_DOUBLE], fullSrc2, cxp_pkg::REG_SP, cxp_pkg::BF3_DOUBLE,
                              cxp_pkg::OPC_STORE);
          end else if (HAS_F) begin
            inst_next = stype(fld.stOff[cxp_pkg::SZ_WORD], fullSrc2, cxp_pkg::REG_SP, cxp_pkg::BF3_WORD,
                              cxp_pkg::OPC_STORE_FP);
          end else begin
            illegal_next = 1'b1;
          end
        end
        cxp_pkg::F3_ST_QUAD_DBLF: begin
          handled_next = 1'b1;
          if (isQuad) begin
            inst_next = stype(fld.stOff[cxp_pkg::SZ_QUAD], fullSrc2, cxp_pkg::REG_SP, cxp_pkg::BF3_QUAD_ST,
                              cxp_pkg::OPC_STORE);
          end else if (HAS_D) begin
            inst_next = stype(fld.stOff[cxp_pkg::SZ_DOUBLE], fullSrc2, cxp_pkg::REG_SP, cxp_pkg::BF3_DOUBLE,
                              cxp_pkg::OPC_STORE_FP);
          end else begin
            illegal_next = 1'b1;
          end
        end
        default: handled_next = 1'b0;
      endcase
    end else if (inst[1:0] == cxp_pkg::QUAD0 && inst[15:13] == cxp_pkg::F3_WIDE) begin
      handled_next = 1'b1;
      // sp add of wide immediate; zero immediate reserved
      if (fld.wideImm == 12'h000) begin
        illegal_next = 1'b1;
      end else begin
        inst_next = itype(fld.wideImm, cxp_pkg::REG_SP, cxp_pkg::BF3_ADD, fld.cmpReg[0], cxp_pkg::OPC_OP_IMM);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      outValid_reg <= 1'b0;
    end else begin
      outValid_reg <= inValid;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      outHandled_reg <= 1'b0;
      outIllegal_reg <= 1'b0;
      outInst_reg <= cxp_pkg::INST_RESET;
    end else if (inValid) begin
      outHandled_reg <= handled_next;
      outIllegal_reg <= illegal_next;
      outInst_reg <= inst_next;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      outImm_reg <= cxp_pkg::INST_RESET;
      outLayout_reg <= cxp_pkg::LAY_NONE;
    end else if (inValid) begin
      outImm_reg <= fld.signImm;
      outLayout_reg <= fld.layout;
    end
  end

  assign outValid = outValid_reg;
  assign outHandled = outHandled_reg;
  assign outIllegal = outIllegal_reg;
  assign outInst = outInst_reg;
  assign outImm = outImm_reg;
  assign outLayout = outLayout_reg;

  // helper decode of the previous request, read only by the checks below
  logic [15:0] instPrev_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      instPrev_reg <= 16'h0000;
    end else begin
      instPrev_reg <= inst;
    end
  end

  logic prevQ2;
  assign prevQ2 = (instPrev_reg[1:0] == cxp_pkg::QUAD2);

  sequence s_take;
    inValid ##1 outValid_reg;
  endsequence

  property p_one_out;
    @(posedge core_clk) disable iff (!rstn)
    s_take |-> !(outHandled_reg && outIllegal_reg && outInst_reg != cxp_pkg::INST_RESET);
  endproperty
  a_one_out: assert property (p_one_out) else $error("illegal result carries an expansion");

  property p_idle;
    @(posedge core_clk) disable iff (!rstn)
    !inValid |=> !outValid_reg;
  endproperty
  a_idle: assert property (p_idle) else $error("output valid without a request");

  property p_quadrant;
    @(posedge core_clk) disable iff (!rstn)
    s_take |-> ((outLayout_reg == cxp_pkg::LAY_NONE) || (instPrev_reg[1:0] != cxp_pkg::QUAD_FULL))
               && ((instPrev_reg[1:0] == cxp_pkg::QUAD2 && instPrev_reg[15]) == (outLayout_reg == cxp_pkg::LAY_SSTORE)
                   || instPrev_reg[15:13] == cxp_pkg::F3_MISC);
  endproperty
  a_quadrant: assert property (p_quadrant) else $error("layout does not match quadrant");

  property p_sign;
    @(posedge core_clk) disable iff (!rstn)
    s_take |-> outImm_reg[31:5] == {27{instPrev_reg[12]}};
  endproperty
  a_sign: assert property (p_sign) else $error("immediate not extended from bit 12");

  property p_sp_base;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 (outHandled_reg && !outIllegal_reg) |-> outInst_reg[19:15] == cxp_pkg::REG_SP;
  endproperty
  a_sp_base: assert property (p_sp_base) else $error("base register is not x2");

  property p_word_load;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 (prevQ2 && instPrev_reg[15:13] == cxp_pkg::F3_WORD && instPrev_reg[11:7] != cxp_pkg::REG_ZERO)
    |-> outInst_reg == {4'h0, instPrev_reg[3:2], instPrev_reg[12], instPrev_reg[6:4], 2'h0, cxp_pkg::REG_SP,
                        cxp_pkg::BF3_WORD, instPrev_reg[11:7], cxp_pkg::OPC_LOAD};
  endproperty
  a_word_load: assert property (p_word_load) else $error("word load expansion wrong");

  property p_dest_zero;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 (prevQ2 && instPrev_reg[15:13] == cxp_pkg::F3_WORD) |-> outIllegal_reg == (instPrev_reg[11:7] == 5'h00);
  endproperty
  a_dest_zero: assert property (p_dest_zero) else $error("x0 word load not flagged");

  property p_word_store;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 (prevQ2 && instPrev_reg[15:13] == cxp_pkg::F3_ST_WORD)
    |-> outInst_reg == {4'h0, instPrev_reg[8:7], instPrev_reg[12], instPrev_reg[6:2], cxp_pkg::REG_SP,
                        cxp_pkg::BF3_WORD, instPrev_reg[11:9], 2'h0, cxp_pkg::OPC_STORE} && !outIllegal_reg;
  endproperty
  a_word_store: assert property (p_word_store) else $error("word store expansion wrong");

  property p_quad_only;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 (prevQ2 && instPrev_reg[15:13] == cxp_pkg::F3_QUAD_DBLF && !isQuad && !HAS_D) |-> outIllegal_reg;
  endproperty
  a_quad_only: assert property (p_quad_only) else $error("unsupported quad load not flagged");

  property p_wide_dest;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 (instPrev_reg[1:0] == cxp_pkg::QUAD0 && instPrev_reg[15:13] == cxp_pkg::F3_WIDE && !outIllegal_reg)
    |-> outInst_reg[11:7] == {2'h1, instPrev_reg[4:2]} && outInst_reg[6:0] == cxp_pkg::OPC_OP_IMM;
  endproperty
  a_wide_dest: assert property (p_wide_dest) else $error("compact destination not in x8..x15");

  property p_dbl_load;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 (prevQ2 && instPrev_reg[15:13] == cxp_pkg::F3_DBL_SGLF && isWide && instPrev_reg[11:7] != 5'h00)
    |-> outInst_reg == {3'h0, instPrev_reg[4:2], instPrev_reg[12], instPrev_reg[6:5], 3'h0, cxp_pkg::REG_SP,
                        cxp_pkg::BF3_DOUBLE, instPrev_reg[11:7], cxp_pkg::OPC_LOAD};
  endproperty
  a_dbl_load: assert property (p_dbl_load) else $error("doubleword load expansion wrong");

  // float loads keep x0 as a legal destination
  property p_sgl_float;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 (prevQ2 && instPrev_reg[15:13] == cxp_pkg::F3_DBL_SGLF && !isWide && HAS_F)
    |-> outInst_reg == {4'h0, instPrev_reg[3:2], instPrev_reg[12], instPrev_reg[6:4], 2'h0, cxp_pkg::REG_SP,
                        cxp_pkg::BF3_WORD, instPrev_reg[11:7], cxp_pkg::OPC_LOAD_FP} && !outIllegal_reg;
  endproperty
  a_sgl_float: assert property (p_sgl_float) else $error("single float load expansion wrong");

  property p_dbl_float;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 (prevQ2 && instPrev_reg[15:13] == cxp_pkg::F3_QUAD_DBLF && !isQuad && HAS_D)
    |-> outInst_reg == {3'h0, instPrev_reg[4:2], instPrev_reg[12], instPrev_reg[6:5], 3'h0, cxp_pkg::REG_SP,
                        cxp_pkg::BF3_DOUBLE, instPrev_reg[11:7], cxp_pkg::OPC_LOAD_FP} && !outIllegal_reg;
  endproperty
  a_dbl_float: assert property (p_dbl_float) else $error("double float load expansion wrong");

  property p_dbl_store;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 (prevQ2 && instPrev_reg[15:13] == cxp_pkg::F3_ST_DBL_SGLF && isWide)
    |-> outInst_reg == {3'h0, instPrev_reg[9:7], instPrev_reg[12], instPrev_reg[6:2], cxp_pkg::REG_SP,
                        cxp_pkg::BF3_DOUBLE, instPrev_reg[11:10], 3'h0, cxp_pkg::OPC_STORE};
  endproperty
  a_dbl_store: assert property (p_dbl_store) else $error("doubleword store expansion wrong");

  property p_quad_store;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 (prevQ2 && instPrev_reg[15:13] == cxp_pkg::F3_ST_QUAD_DBLF && isQuad)
    |-> outInst_reg == {2'h0, instPrev_reg[10:7], instPrev_reg[12], instPrev_reg[6:2], cxp_pkg::REG_SP,
                        cxp_pkg::BF3_QUAD_ST, instPrev_reg[11], 4'h0, cxp_pkg::OPC_STORE};
  endproperty
  a_quad_store: assert property (p_quad_store) else $error("quadword store expansion wrong");

  property p_sgl_fstore;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 (prevQ2 && instPrev_reg[15:13] == cxp_pkg::F3_ST_DBL_SGLF && !isWide && HAS_F)
    |-> outInst_reg == {4'h0, instPrev_reg[8:7], instPrev_reg[12], instPrev_reg[6:2], cxp_pkg::REG_SP,
                        cxp_pkg::BF3_WORD, instPrev_reg[11:9], 2'h0, cxp_pkg::OPC_STORE_FP};
  endproperty
  a_sgl_fstore: assert property (p_sgl_fstore) else $error("single float store expansion wrong");

  property p_dbl_fstore;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 (prevQ2 && instPrev_reg[15:13] == cxp_pkg::F3_ST_QUAD_DBLF && !isQuad && HAS_D)
    |-> outInst_reg == {3'h0, instPrev_reg[9:7], instPrev_reg[12], instPrev_reg[6:2], cxp_pkg::REG_SP,
                        cxp_pkg::BF3_DOUBLE, instPrev_reg[11:10], 3'h0, cxp_pkg::OPC_STORE_FP};
  endproperty
  a_dbl_fstore: assert property (p_dbl_fstore) else $error("double float store expansion wrong");

  property p_no_expand;
    @(posedge core_clk) disable iff (!rstn)
    s_take ##0 outIllegal_reg |-> outHandled_reg && outInst_reg == cxp_pkg::INST_RESET;
  endproperty
  a_no_expand: assert property (p_no_expand) else $error("illegal result is not empty");
endmodule : cxp_expander
`default_nettype wire

/* File: sim/cxp_decoder_model.sv */
// downstream full-width decoder model that consumes the expander results
`timescale 1ns/10ps
`default_nettype none
module cxp_decoder_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic resValid,
  input wire logic resHandled,
  input wire logic resIllegal,
  input wire logic [31:0] resInst,
  output logic badForm
);
  logic knownOpc;
  assign knownOpc = resInst[6:0] inside {7'h03, 7'h07, 7'h0F, 7'h13, 7'h23, 7'h27};
  // sticky until reset, so one bad result since the last reset is never lost
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      badForm <= 1'b0;
    end else if (resValid && resHandled) begin
      if (resIllegal ? (resInst != 32'h0000_0000) : (!knownOpc || resInst[19:15] != 5'h02)) begin
        badForm <= 1'b1;
      end
    end
  end
endmodule : cxp_decoder_model
`default_nettype wire

/* File: sim/compressed_format_sp_ldst_expander_bench.sv */
// self-checking bench for the stack-pointer load/store expander
`timescale 1ns/10ps
`default_nettype none
module compressed_format_sp_ldst_expander_bench;
  typedef struct packed {
    logic h;
    logic il;
    logic [31:0] ins;
    logic [31:0] imm;
    logic [3:0] ly;
  } cxp_exp_t;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic inValid = 1'b0;
  logic [15:0] inst = 16'h0000;
  logic oV[4];
  logic oH[4];
  logic oIl[4];
  logic [31:0] oInst[4];
  logic [31:0] oImm[4];
  cxp_pkg::cxp_layout_t oLay[4];
  logic badForm[4];
  logic [31:0] last[4] = '{default: 32'h0000_0000};
  logic [10:0] pats[6] = '{11'h7FF, 11'h000, 11'h41F, 11'h400, 11'h2AA, 11'h555};
  logic [31:0] seed = 32'hF1F80850;
  cxp_exp_t q[$];
  int mismatches = 0;
  int totalChecks = 0;

  // four builds: 32, 64, 128 bits, and 32 bits without float
  for (genvar k = 0; k < 4; k++) begin : g_cfg
    cxp_expander #(.XLEN(k == 1 ? 64 : k == 2 ? 128 : 32), .HAS_F(k != 3), .HAS_D(k != 3)) u_dut (
      .core_clk(core_clk), .rstn(rstn), .inValid(inValid), .inst(inst), .outValid(oV[k]),
      .outHandled(oH[k]), .outIllegal(oIl[k]), .outInst(oInst[k]), .outImm(oImm[k]), .outLayout(oLay[k]));
    cxp_decoder_model u_sink (.core_clk(core_clk), .rstn(rstn), .resValid(oV[k]), .resHandled(oH[k]),
      .resIllegal(oIl[k]), .resInst(oInst[k]), .badForm(badForm[k]));
  end

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic cxp_exp_t expand(input int xl, input logic hf, input logic [15:0] i);
    cxp_exp_t e;
    logic [2:0] f;
    logic [2:0] b;
    logic [6:0] op;
    logic [11:0] o;
    logic [11:0] ow;
    logic [11:0] od;
    logic [11:0] oq;
    f = i[15:13];
    e = '0;
    ow = f[2] ? {4'h0, i[8:7], i[12:9], 2'h0} : {4'h0, i[3:2], i[12], i[6:4], 2'h0};
    od = f[2] ? {3'h0, i[9:7], i[12:10], 3'h0} : {3'h0, i[4:2], i[12], i[6:5], 3'h0};
    oq = f[2] ? {2'h0, i[10:7], i[12:11], 4'h0} : {2'h0, i[5:2], i[12], i[6], 4'h0};
    e.imm = {{27{i[12]}}, i[6:2]};
    // layout codes, F means not compared
    e.ly = 4'hF;
    if (i[1:0] == 2'h0) e.ly = f == 3'h0 ? 4'h3 : f == 3'h4 ? 4'h9 : f[2] ? 4'h5 : 4'h4;
    if (i[1:0] == 2'h2) e.ly = f == 3'h4 ? 4'h0 : f[2] ? 4'h2 : 4'h1;
    if (i[1:0] == 2'h1 && f != 3'h4) e.ly = (f == 3'h5 || (f == 3'h1 && xl == 32)) ? 4'h8 : f[2] ? 4'h7 : 4'h1;
    if (i[1:0] == 2'h0 && f == 3'h0) begin
      o = {2'h0, i[10:7], i[12:11], i[5], i[6], 2'h0};
      e.h = 1'b1;
      e.il = (o == 12'h000);
      e.ins = {o, 5'h02, 3'h0, 2'h1, i[4:2], 7'h13};
    end else if (i[1:0] == 2'h2 && f != 3'h0 && f != 3'h4) begin
      e.h = 1'b1;
      {o, b, op, e.il} = {ow, 3'h2, f[2] ? 7'h23 : 7'h03, i[11:7] == 5'h00 && !f[2]};
      if (f[1:0] == 2'h3 && xl != 32) {o, b} = {od, 3'h3};
      else if (f[1:0] == 2'h3) {op, e.il} = {op | 7'h04, !hf};
      else if (f[1:0] == 2'h1 && xl == 128) {o, b, op} = {oq, f[2] ? 3'h4 : 3'h2, f[2] ? 7'h23 : 7'h0F};
      else if (f[1:0] == 2'h1) {o, b, op, e.il} = {od, 3'h3, op | 7'h04, !hf};
      e.ins = f[2] ? {o[11:5], i[6:2], 5'h02, b, o[4:0], op} : {o, 5'h02, b, i[11:7], op};
    end
    if (e.il) e.ins = 32'h0000_0000;
    return e;
  endfunction : expand

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkWord

  task automatic chkBit(input logic got, input logic exp);
    chkWord({31'h0, got}, {31'h0, exp});
  endtask : chkBit

  task automatic send(input logic [15:0] i);
    inValid = 1'b1;
    inst = i;
    for (int k = 0; k < 4; k++) q.push_back(expand(k == 1 ? 64 : k == 2 ? 128 : 32, k != 3, i));
    @(posedge core_clk);
    #1;
  endtask : send

  // inverted instruction while idle shows it is not sampled
  task automatic idle(input int n);
    inValid = 1'b0;
    inst = ~inst;
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask : idle

  task automatic rstChk();
    for (int k = 0; k < 4; k++) begin
      chkBit(oV[k] | oH[k] | oIl[k], 1'b0);
      chkWord(oInst[k] | oImm[k], 32'h0000_0000);
      chkWord(32'(oLay[k]), 32'h0000_0009);
    end
  endtask : rstChk

  always @(negedge core_clk) begin : watch
    cxp_exp_t e;
    if (rstn === 1'b1 && oV[0] === 1'b1) begin
      for (int k = 0; k < 4; k++) begin
        chkBit(q.size() > 0, 1'b1);
        e = q.size() > 0 ? q.pop_front() : '0;
        chkBit(oV[k], 1'b1);
        chkBit(oH[k], e.h);
        chkBit(oIl[k], e.il);
        chkWord(oInst[k], e.ins);
        chkWord(oImm[k], e.imm);
        if (e.ly != 4'hF) chkWord(32'(oLay[k]), {28'h0, e.ly});
        last[k] = oInst[k];
      end
    end else if (rstn === 1'b1) begin
      for (int k = 0; k < 4; k++) begin
        chkBit(oV[k], 1'b0);
        chkWord(oInst[k], last[k]);
      end
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    rstChk();
    rstn = 1'b1;
    send(16'h4082);
    // field extremes for quadrants 0 to 2 and every function code, back to back
    for (int qd = 0; qd < 3; qd++) begin
      for (int f = 0; f < 8; f++) begin
        foreach (pats[p]) send({f[2:0], pats[p], qd[1:0]});
      end
    end
    idle(2);
    repeat (600) begin
      seed = lfsr(seed);
      send(seed[16] ? {seed[15:2], 2'h2} : seed[15:0]);
      if (seed[20:19] == 2'h0) idle(1 + int'(seed[22]));
    end
    send(16'h4082);
    // reset lands on the answer cycle of a pending request
    rstn = 1'b0;
    q.delete();
    last = '{default: 32'h0000_0000};
    idle(2);
    rstChk();
    rstn = 1'b1;
    send(16'h4082);
    idle(3);
    for (int k = 0; k < 4; k++) chkBit(badForm[k], 1'b0);
    chkBit(q.size() == 0, 1'b1);
    closeOut();
  end

  // run needs about 1000 cycles; ten times that marks a hang
  initial begin
    #200000;
    mismatches++;
    closeOut();
  end

  task automatic closeOut();
    $display("checks=%0d mismatches=%0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : closeOut
endmodule : compressed_format_sp_ldst_expander_bench
`default_nettype wire
